// ==== verilog/sync_slave_serial_sleep.sv ====
// synchronous slave serial unit with axi4-lite registers and sleep wake
//
// Decided for this implementation: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "sync_serial_cfg.svh"
`default_nettype none

module sync_slave_serial_sleep #(
  parameter int ADDR_W = 8,
  parameter int DEPTH  = 2
) (
  // clock and reset
  input  wire  logic              ref_clk_in,
  input  wire  logic              rst_n_in,
  // axi4-lite write channels
  input  wire  logic [ADDR_W-1:0] awaddr_in,
  input  wire  logic              awvalid_in,
  output logic                    awready_out,
  input  wire  logic [31:0]       wdata_in,
  input  wire  logic [3:0]        wstrb_in,
  input  wire  logic              wvalid_in,
  output logic                    wready_out,
  output logic [1:0]              bresp_out,
  output logic                    bvalid_out,
  input  wire  logic              bready_in,
  // axi4-lite read channels
  input  wire  logic [ADDR_W-1:0] araddr_in,
  input  wire  logic              arvalid_in,
  output logic                    arready_out,
  output logic [31:0]             rdata_out,
  output logic [1:0]              rresp_out,
  output logic                    rvalid_out,
  input  wire  logic              rready_in,
  // processor side
  input  wire  logic              sleep_in,
  output logic                    irq_out,
  output logic                    wake_out,
  output logic                    vector_out,
  // serial pins
  input  wire  logic              serial_clock_pin_in,
  input  wire  logic              serial_data_pin_in,
  output logic                    serial_data_pin_out,
  output logic                    serial_data_pin_oe_out
);

  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [7:0]                 baud, interrupt_control, pie, pir, rxstat;
    logic [7:0]                 brg_lo, brg_hi, portc, txstat;
    logic [7:0]                 evt_st, evt_mask, waddr, wdata;
    logic                       ck_s1, ck_s2, ck_d, dt_s1, dt_s2;
    logic [8:0]                 receive_shift_register, txbuf, transmit_shift_register;
    logic [3:0]                 rx_cnt, tx_cnt;
    logic [DEPTH-1:0][8:0]      fifo;
    logic [PW-1:0]              rd_ptr, wr_ptr;
    logic [PW:0]                count;
    logic                       overrun_error_flag, txbuf_full;
    sync_serial_pkg::tx_state_t tx_st;
    logic                       awready, wready, aw_got, w_got, wlane;
    logic                       bvalid, arready, rvalid;
    logic [1:0]                 bresp, rresp;
    logic [31:0]                rdata;
    logic                       irq, wake, vec, dout, doe;
  } state_t;

  state_t     s;
  state_t     next_s;
  logic       ck_lvl, sample_edge, shift_edge;
  logic       slave, rx_on, tx_on;
  logic [3:0] rx_last, tx_last;
  logic [8:0] rx_word, head;
  logic       push, pop, ev_rx, ev_tx, ev_ov;
  logic       aw_fire, w_fire, ar_fire, wr_fire;
  logic [7:0] rd_byte, clr;
  logic       rd_ok, rc_int, tx_int;

  // whole next state in one place; every flop updates every edge
  always_comb
  begin
    next_s  = s;
    push    = 1'b0;
    pop     = 1'b0;
    ev_rx   = 1'b0;
    ev_tx   = 1'b0;
    ev_ov   = 1'b0;
    clr     = `RST_BYTE;
    rd_byte = `RST_BYTE;
    rd_ok   = 1'b1;

    // pins pass two flops before anything looks at them
    next_s.ck_s1 = serial_clock_pin_in;
    next_s.ck_s2 = s.ck_s1;
    next_s.dt_s1 = serial_data_pin_in;
    next_s.dt_s2 = s.dt_s1;
    // polarity folds into the level so one edge pair serves both settings
    ck_lvl       = s.ck_s2 ^ s.baud[`B_CLOCK_POLARITY_SELECT];
    next_s.ck_d  = ck_lvl;
    sample_edge  = ck_lvl & ~s.ck_d;
    shift_edge   = ~ck_lvl & s.ck_d;

    // mode decode; only the pin clock moves the shifters
    slave = s.txstat[`B_SYNC] & s.rxstat[`B_PORT_ENABLE]
            & ~s.txstat[`B_CLOCK_SOURCE_SELECT];
    // no other mode is built, so nothing shifts outside slave mode,
    // asleep or awake
    rx_on = slave & s.rxstat[`B_CONTINUOUS_RECEIVE_ENABLE];
    tx_on = slave & ~s.rxstat[`B_CONTINUOUS_RECEIVE_ENABLE] & s.txstat[`B_TXEN];
    rx_last = s.rxstat[`B_RX9] ? `LAST_9BIT : `LAST_8BIT;
    tx_last = s.txstat[`B_TX9] ? `LAST_9BIT : `LAST_8BIT;
    head    = (s.count != '0) ? s.fifo[s.rd_ptr] : 9'h000;

    // receive shifter, lsb first, clocked from the pin edges
    rx_word = s.receive_shift_register;
    rx_word[s.rx_cnt] = s.dt_s2;
    rx_word[8] = rx_word[8] & s.rxstat[`B_RX9];
    if (!s.rxstat[`B_CONTINUOUS_RECEIVE_ENABLE])
    begin
      next_s.overrun_error_flag   = 1'b0;
      next_s.rx_cnt = 4'h0;
    end
    else if (sample_edge && rx_on && !s.overrun_error_flag)
    begin
      next_s.receive_shift_register = rx_word;
      if (s.rx_cnt == rx_last)
      begin
        next_s.rx_cnt = 4'h0;
        if (s.count == (PW+1)'(DEPTH))
        begin
          next_s.overrun_error_flag = 1'b1;
          ev_ov       = 1'b1;
        end
        else
        begin
          push  = 1'b1;
          ev_rx = 1'b1;
        end
      end
      else
      begin
        next_s.rx_cnt = s.rx_cnt + `CNT_STEP;
      end
    end

    // transmit shifter; buffer reloads as soon as the shifter drains
    case (s.tx_st)
      sync_serial_pkg::TX_IDLE:
      begin
        if (tx_on && s.txbuf_full)
        begin
          next_s.transmit_shift_register        = s.txbuf;
          next_s.txbuf_full = 1'b0;
          next_s.tx_cnt     = 4'h0;
          next_s.tx_st      = sync_serial_pkg::TX_SHIFT;
          ev_tx             = 1'b1;
        end
      end
      sync_serial_pkg::TX_SHIFT:
      begin
        if (!tx_on)
        begin
          next_s.tx_st = sync_serial_pkg::TX_IDLE;
        end
        else if (shift_edge)
        begin
          if (s.tx_cnt != tx_last)
          begin
            next_s.tx_cnt = s.tx_cnt + `CNT_STEP;
          end
          else if (s.txbuf_full)
          begin
            next_s.transmit_shift_register        = s.txbuf;
            next_s.txbuf_full = 1'b0;
            next_s.tx_cnt     = 4'h0;
            ev_tx             = 1'b1;
          end
          else
          begin
            next_s.tx_st = sync_serial_pkg::TX_IDLE;
          end
        end
      end
      default:
      begin
        next_s.tx_st = sync_serial_pkg::TX_IDLE;
      end
    endcase

    // write address and data are taken in either order, then applied
    aw_fire = awvalid_in & s.awready;
    w_fire  = wvalid_in & s.wready;
    wr_fire = s.aw_got & s.w_got;
    if (aw_fire)
    begin
      next_s.aw_got = 1'b1;
      next_s.waddr  = awaddr_in[7:0];
    end
    if (w_fire)
    begin
      next_s.w_got = 1'b1;
      next_s.wdata = wdata_in[7:0];
      next_s.wlane = wstrb_in[0];
    end
    if (s.bvalid && bready_in)
    begin
      next_s.bvalid = 1'b0;
    end
    if (wr_fire)
    begin
      next_s.aw_got = 1'b0;
      next_s.w_got  = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp  = `RESP_OKAY;
      case ({s.waddr[7:2], 2'b00})
        `REG_BAUD:
          if (s.wlane) next_s.baud = (s.wdata & `MASK_BAUD)
                                     | (s.baud & ~`MASK_BAUD);
        `REG_INTERRUPT_CONTROL:
          if (s.wlane) next_s.interrupt_control = s.wdata;
        `REG_PIE:
          if (s.wlane) next_s.pie = s.wdata;
        `REG_PIR:
          if (s.wlane) next_s.pir = s.wdata & `MASK_PIR;
        `REG_RXSTAT:
          if (s.wlane) next_s.rxstat = s.wdata & `MASK_RXST;
        `REG_BRG_LO:
          if (s.wlane) next_s.brg_lo = s.wdata;
        `REG_BRG_HI:
          if (s.wlane) next_s.brg_hi = s.wdata;
        `REG_PORTC:
          if (s.wlane) next_s.portc = s.wdata;
        `REG_TXSTAT:
          if (s.wlane) next_s.txstat = s.wdata & `MASK_TXST;
        `REG_TXDATA:
          if (s.wlane)
          begin
            // applied after the reload, so a same-cycle write is kept
            next_s.txbuf      = {s.txstat[`B_TX9D], s.wdata};
            next_s.txbuf_full = 1'b1;
          end
        `REG_EVT_ST:
          if (s.wlane) clr = s.wdata & `MASK_EVT;
        `REG_EVT_MASK:
          if (s.wlane) next_s.evt_mask = s.wdata & `MASK_EVT;
        `REG_RXDATA:
          next_s.bresp = `RESP_OKAY;
        default:
          next_s.bresp = `RESP_SLVERR;
      endcase
    end

    // read mux; derived flags are composed from live state
    ar_fire = arvalid_in & s.arready;
    case ({araddr_in[7:2], 2'b00})
      `REG_BAUD:
      begin
        rd_byte = s.baud;
        rd_byte[`B_RCIDL] = ~rx_on;
      end
      `REG_INTERRUPT_CONTROL:   rd_byte = s.interrupt_control;
      `REG_PIE:      rd_byte = s.pie;
      `REG_PIR:
      begin
        rd_byte = s.pir;
        rd_byte[`B_RECEIVE_COMPLETE_FLAG] = (s.count != '0);
        rd_byte[`B_TRANSMIT_BUFFER_EMPTY_FLAG] = ~s.txbuf_full;
      end
      `REG_RXDATA:   rd_byte = head[7:0];
      `REG_RXSTAT:
      begin
        rd_byte = s.rxstat;
        rd_byte[`B_OVERRUN_ERROR_FLAG] = s.overrun_error_flag;
        rd_byte[`B_RECEIVED_NINTH_BIT] = head[8];
      end
      `REG_BRG_LO:   rd_byte = s.brg_lo;
      `REG_BRG_HI:   rd_byte = s.brg_hi;
      `REG_PORTC:    rd_byte = s.portc;
      `REG_TXDATA:   rd_byte = `RST_BYTE;
      `REG_TXSTAT:
      begin
        rd_byte = s.txstat;
        rd_byte[`B_TRMT] = (s.tx_st == sync_serial_pkg::TX_IDLE);
      end
      `REG_EVT_ST:   rd_byte = s.evt_st;
      `REG_EVT_MASK: rd_byte = s.evt_mask;
      default:       rd_ok   = 1'b0;
    endcase
    if (s.rvalid && rready_in)
    begin
      next_s.rvalid = 1'b0;
    end
    if (ar_fire)
    begin
      next_s.rvalid = 1'b1;
      next_s.rdata  = {24'h000000, rd_byte};
      next_s.rresp  = rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      pop = ({araddr_in[7:2], 2'b00} == `REG_RXDATA)
            && (s.count != '0);
    end

    // queue pointers and occupancy
    if (push)
    begin
      next_s.fifo[s.wr_ptr] = rx_word;
      next_s.wr_ptr = s.wr_ptr + 1'b1;
    end
    if (pop)
    begin
      next_s.rd_ptr = s.rd_ptr + 1'b1;
    end
    next_s.count = s.count + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};

    // port disable clears both shifters, the queue and the overrun flag but keeps the settings and sticky events
    if (!s.rxstat[`B_PORT_ENABLE])
    begin
      next_s.overrun_error_flag       = 1'b0;
      next_s.rx_cnt     = 4'h0;
      next_s.rd_ptr     = '0;
      next_s.wr_ptr     = '0;
      next_s.count      = '0;
      next_s.txbuf_full = 1'b0;
      next_s.tx_cnt     = 4'h0;
      next_s.tx_st      = sync_serial_pkg::TX_IDLE;
    end

    // sticky events: a set in the clearing cycle wins
    next_s.evt_st = s.evt_st & ~clr;
    next_s.evt_st[`B_EV_RX] = next_s.evt_st[`B_EV_RX] | ev_rx;
    next_s.evt_st[`B_EV_TX] = next_s.evt_st[`B_EV_TX] | ev_tx;
    next_s.evt_st[`B_EV_OV] = next_s.evt_st[`B_EV_OV] | ev_ov;
    next_s.irq = |(next_s.evt_st & next_s.evt_mask);

    // wake and vector requests toward the core
    rc_int = (next_s.count != '0) & s.pie[`B_RECEIVE_INTERRUPT_ENABLE];
    tx_int = ~next_s.txbuf_full & s.pie[`B_TRANSMIT_INTERRUPT_ENABLE]
             & s.interrupt_control[`B_PERIPHERAL_INTERRUPT_ENABLE];
    next_s.wake = sleep_in & (rc_int | tx_int);
    next_s.vec  = (rc_int | tx_int) & s.interrupt_control[`B_GIE];

    // data pin drive; line rests high while no character is shifting
    next_s.doe  = tx_on;
    next_s.dout = (next_s.tx_st == sync_serial_pkg::TX_SHIFT)
                  ? next_s.transmit_shift_register[next_s.tx_cnt] : 1'b1;

    // readiness follows the registered handshake state
    next_s.awready = ~next_s.aw_got & ~next_s.bvalid;
    next_s.wready  = ~next_s.w_got & ~next_s.bvalid;
    next_s.arready = ~next_s.rvalid;
  end

  // single state register
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  // outputs straight from flops
  assign awready_out            = s.awready;
  assign wready_out             = s.wready;
  assign bresp_out              = s.bresp;
  assign bvalid_out             = s.bvalid;
  assign arready_out            = s.arready;
  assign rdata_out              = s.rdata;
  assign rresp_out              = s.rresp;
  assign rvalid_out             = s.rvalid;
  assign irq_out                = s.irq;
  assign wake_out               = s.wake;
  assign vector_out             = s.vec;
  assign serial_data_pin_out    = s.dout;
  assign serial_data_pin_oe_out = s.doe;

endmodule : sync_slave_serial_sleep

`default_nettype wire

// ==== verilog/sync_serial_cfg.svh ====
// offsets, field positions, reset values and counts of the serial unit
`ifndef SYNC_SERIAL_CFG_SVH
`define SYNC_SERIAL_CFG_SVH

// register byte addresses
`define REG_BAUD     8'h00
`define REG_INTERRUPT_CONTROL   8'h04
`define REG_PIE      8'h08
`define REG_PIR      8'h0c
`define REG_RXDATA   8'h10
`define REG_RXSTAT   8'h14
`define REG_BRG_LO   8'h18
`define REG_BRG_HI   8'h1c
`define REG_PORTC    8'h20
`define REG_TXDATA   8'h24
`define REG_TXSTAT   8'h28
`define REG_EVT_ST   8'h2c
`define REG_EVT_MASK 8'h30

// field positions
`define B_RCIDL 6
`define B_CLOCK_POLARITY_SELECT  4
`define B_GIE   7
`define B_PERIPHERAL_INTERRUPT_ENABLE  6
`define B_RECEIVE_INTERRUPT_ENABLE  5
`define B_TRANSMIT_INTERRUPT_ENABLE  4
`define B_RECEIVE_COMPLETE_FLAG  5
`define B_TRANSMIT_BUFFER_EMPTY_FLAG  4
`define B_PORT_ENABLE  7
`define B_RX9   6
`define B_CONTINUOUS_RECEIVE_ENABLE  4
`define B_OVERRUN_ERROR_FLAG  1
`define B_RECEIVED_NINTH_BIT  0
`define B_CLOCK_SOURCE_SELECT  7
`define B_TX9   6
`define B_TXEN  5
`define B_SYNC  4
`define B_TRMT  1
`define B_TX9D  0
`define B_EV_RX 0
`define B_EV_TX 1
`define B_EV_OV 2

// writable bit masks and reset value
`define MASK_BAUD  8'h9b
`define MASK_PIR   8'h4f
`define MASK_RXST  8'hf8
`define MASK_TXST  8'hfd
`define MASK_EVT   8'h07
`define RST_BYTE   8'h00

// character lengths as last bit index, bus answers
`define LAST_8BIT  4'h7
`define LAST_9BIT  4'h8
`define CNT_STEP   4'h1
`define RESP_OKAY  2'b00
`define RESP_SLVERR 2'b10

`endif

// ==== verilog/sync_serial_pkg.sv ====
// types shared by the synchronous slave serial unit
package sync_serial_pkg;

  // transmit shifter state, one bit apart along the path
  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_SHIFT = 2'b01
  } tx_state_t;

endpackage : sync_serial_pkg

// ==== test/sync_serial_assertions.sv ====
// port-level assertions of the synchronous slave serial unit
`timescale 1ns/1ps
`include "sync_serial_cfg.svh"
`default_nettype none
module sync_serial_checker #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic              ref_clk_in,
  input wire logic              rst_n_in,
  // register bus
  input wire logic [ADDR_W-1:0] awaddr_in,
  input wire logic              awvalid_in,
  input wire logic              awready_out,
  input wire logic              wvalid_in,
  input wire logic              wready_out,
  input wire logic [1:0]        bresp_out,
  input wire logic              bvalid_out,
  input wire logic              bready_in,
  input wire logic [ADDR_W-1:0] araddr_in,
  input wire logic              arvalid_in,
  input wire logic              arready_out,
  input wire logic [31:0]       rdata_out,
  input wire logic [1:0]        rresp_out,
  input wire logic              rvalid_out,
  input wire logic              rready_in,
  // processor and serial side
  input wire logic              sleep_in,
  input wire logic              wake_out,
  input wire logic              serial_clock_pin_in,
  input wire logic              serial_data_pin_out
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  // steps of a bus transfer and a quiet link clock
  sequence wr_taken;
    awvalid_in && awready_out && wvalid_in && wready_out;
  endsequence
  sequence rd_taken;
    arvalid_in && arready_out;
  endsequence
  sequence clk_quiet;
    $stable(serial_clock_pin_in) [*6];
  endsequence

  write_answer_a: assert property (wr_taken |-> ##2 bvalid_out)
    else $error("write answer not two cycles after hand-off");
  read_answer_a: assert property (rd_taken |=> rvalid_out)
    else $error("read answer not one cycle after hand-off");
  bresp_hold_a: assert property (bvalid_out && !bready_in |=>
    bvalid_out && $stable(bresp_out))
    else $error("write response dropped before taken");
  rdata_hold_a: assert property (rvalid_out && !rready_in |=>
    rvalid_out && $stable(rdata_out))
    else $error("read data dropped before taken");
  read_bad_addr_a: assert property (rd_taken ##0 araddr_in[7:2] > 6'h0c
    |=> rresp_out == `RESP_SLVERR && rdata_out == 32'h0)
    else $error("unmapped read not refused");
  write_bad_addr_a: assert property (wr_taken ##0 awaddr_in[7:2] > 6'h0c
    |-> ##2 bresp_out == `RESP_SLVERR)
    else $error("unmapped write not refused");
  wake_sleep_a: assert property (wake_out |-> $past(sleep_in))
    else $error("wake raised while awake");
  sleep_quiet_a: assert property (clk_quiet ##0 sleep_in |=>
    $stable(serial_data_pin_out))
    else $error("data pin moved with no link clock edge");
endmodule : sync_serial_checker

bind sync_slave_serial_sleep sync_serial_checker #(
  .ADDR_W(ADDR_W)
) sync_serial_checker_inst (
  .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
  .awaddr_in(awaddr_in), .awvalid_in(awvalid_in),
  .awready_out(awready_out), .wvalid_in(wvalid_in),
  .wready_out(wready_out), .bresp_out(bresp_out),
  .bvalid_out(bvalid_out), .bready_in(bready_in),
  .araddr_in(araddr_in), .arvalid_in(arvalid_in),
  .arready_out(arready_out), .rdata_out(rdata_out),
  .rresp_out(rresp_out), .rvalid_out(rvalid_out),
  .rready_in(rready_in), .sleep_in(sleep_in), .wake_out(wake_out),
  .serial_clock_pin_in(serial_clock_pin_in),
  .serial_data_pin_out(serial_data_pin_out)
);
`default_nettype wire

// ==== test/sync_master_model.sv ====
// behavioural external master that clocks the serial unit
`timescale 1ns/1ps
`default_nettype none
module sync_master_model (
  // serial pins seen from the master
  output logic      sck_out,
  output logic      sdat_out,
  input  wire logic sdat_in
);
  // clock rests low between frames
  initial
  begin
    sck_out = 1'b0;
    sdat_out = 1'b1;
  end

  // skew keeps the link clock out of phase with the system clock;
  // data moves mid-low so either polarity samples a settled bit
  task automatic send(input logic [8:0] v, input int n);
    #3.3;
    for (int i = 0; i < n; i++)
    begin
      sdat_out = v[i];
      #31.25 sck_out = 1'b1;
      #62.5 sck_out = 1'b0;
      #31.25;
    end
    sdat_out = ~sdat_out; // released line must not keep the last bit
  endtask : send

  // capture lsb first at each rising edge
  task automatic get(output logic [8:0] v, input int n);
    v = '0;
    #3.3;
    for (int i = 0; i < n; i++)
    begin
      #62.5 sck_out = 1'b1;
      v[i] = sdat_in;
      #62.5 sck_out = 1'b0;
    end
  endtask : get
endmodule : sync_master_model
`default_nettype wire

// ==== test/tb.sv ====
// self-checking bench of the synchronous slave serial unit
`timescale 1ns/1ps
`include "sync_serial_cfg.svh"
`default_nettype none
`define CHK(n, e, s) \
  begin \
    compares++; \
    if ((s) !== (e)) \
    begin \
      n_errors++; \
      $display("Error %s expected %h seen %h", n, e, s); \
    end \
  end
module tb;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wval;
    logic [7:0] rval;
    logic [1:0] resp;
  } row_t;
  logic        clk;
  logic        rst_n = 1'b0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        sleep = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [1:0]  bresp, rresp, rsp;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        irq, wake, vec, sck, sdi, sdo, soe;
  logic [7:0]  rd_val;
  logic [8:0]  got;
  int          n_errors, compares, cyc;
  // plain register rows: address, written, read back, answer
  row_t rows [7] = '{
    '{`REG_BRG_LO, 8'ha5, 8'ha5, `RESP_OKAY},
    '{`REG_BRG_HI, 8'h5a, 8'h5a, `RESP_OKAY},
    '{`REG_PORTC, 8'h3c, 8'h3c, `RESP_OKAY},
    '{`REG_BAUD, 8'hff, 8'hdb, `RESP_OKAY},
    '{`REG_BAUD, 8'h00, 8'h40, `RESP_OKAY},
    '{`REG_EVT_MASK, 8'hff, 8'h07, `RESP_OKAY},
    '{8'h40, 8'h11, 8'h00, `RESP_SLVERR}};

  sync_slave_serial_sleep sync_slave_serial_sleep_inst (
    .ref_clk_in(clk), .rst_n_in(rst_n),
    .awaddr_in(awaddr), .awvalid_in(awvalid), .awready_out(awready),
    .wdata_in(wdata), .wstrb_in(4'h1), .wvalid_in(wvalid),
    .wready_out(wready), .bresp_out(bresp), .bvalid_out(bvalid),
    .bready_in(bready), .araddr_in(araddr), .arvalid_in(arvalid),
    .arready_out(arready), .rdata_out(rdata), .rresp_out(rresp),
    .rvalid_out(rvalid), .rready_in(rready), .sleep_in(sleep),
    .irq_out(irq), .wake_out(wake), .vector_out(vec),
    .serial_clock_pin_in(sck), .serial_data_pin_in(sdi),
    .serial_data_pin_out(sdo), .serial_data_pin_oe_out(soe));
  sync_master_model sync_master_model_inst (
    .sck_out(sck), .sdat_out(sdi), .sdat_in(sdo));

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (!bvalid);
    rsp = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arready)
        arvalid <= 1'b0;
    end
    while (!rvalid);
    rd_val = rdata[7:0];
    rsp = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    `CHK("rdata", e, rd_val)
  endtask : chk

  task automatic chkb(input logic [7:0] a, input int b, input logic e);
    rd(a);
    `CHK("flag", e, rd_val[b])
  endtask : chkb

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt

  task automatic final_report;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report

  initial
  begin
    clk = 1'b0;
    forever
      #5 clk = ~clk;
  end

  // a hang is cut short well past the expected run
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      n_errors++;
      final_report();
    end
  end

  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    chk(`REG_RXSTAT, 8'h00);
    chk(`REG_INTERRUPT_CONTROL, 8'h00);
    foreach (rows[i])
    begin
      wr(rows[i].addr, rows[i].wval);
      `CHK("bresp", rows[i].resp, rsp)
      rd(rows[i].addr);
      `CHK("rdata", rows[i].rval, rd_val)
      `CHK("rresp", rows[i].resp, rsp)
    end
    // receive while asleep: wake, vector and interrupt
    wr(`REG_TXSTAT, 8'h10);
    wr(`REG_RXSTAT, 8'h90);
    wr(`REG_PIE, 8'h20);
    wr(`REG_EVT_MASK, 8'h01);
    wr(`REG_INTERRUPT_CONTROL, 8'h80);
    sleep <= 1'b1;
    sync_master_model_inst.send(9'h05a, 8);
    wt(10);
    `CHK("wake", 1'b1, wake)
    `CHK("vector", 1'b1, vec)
    `CHK("irq", 1'b1, irq)
    sleep <= 1'b0;
    chkb(`REG_PIR, `B_RECEIVE_COMPLETE_FLAG, 1'b1);
    chk(`REG_RXDATA, 8'h5a);
    chkb(`REG_PIR, `B_RECEIVE_COMPLETE_FLAG, 1'b0);
    wr(`REG_EVT_ST, 8'h01);
    wt(2);
    `CHK("irq", 1'b0, irq)
    // receive interrupt enable off keeps the sleeper asleep
    wr(`REG_PIE, 8'h00);
    sleep <= 1'b1;
    sync_master_model_inst.send(9'h03c, 8);
    wt(10);
    `CHK("wake", 1'b0, wake)
    sleep <= 1'b0;
    chk(`REG_RXDATA, 8'h3c);
    // nine-bit character
    wr(`REG_RXSTAT, 8'hd0);
    sync_master_model_inst.send(9'h1a3, 9);
    wt(10);
    chk(`REG_RXSTAT, 8'hd1);
    chk(`REG_RXDATA, 8'ha3);
    // third character overruns the two-deep queue
    wr(`REG_RXSTAT, 8'h90);
    for (int i = 1; i < 4; i++)
      sync_master_model_inst.send(9'(i * 17), 8);
    wt(10);
    chk(`REG_RXSTAT, 8'h92);
    wr(`REG_RXSTAT, 8'h80);
    chk(`REG_RXSTAT, 8'h80);
    chk(`REG_RXDATA, 8'h11);
    wr(`REG_RXSTAT, 8'h00);
    chkb(`REG_PIR, `B_RECEIVE_COMPLETE_FLAG, 1'b0);
    // no receive with continuous receive off or clock source set
    wr(`REG_RXSTAT, 8'h80);
    sync_master_model_inst.send(9'h055, 8);
    wr(`REG_TXSTAT, 8'h90);
    wr(`REG_RXSTAT, 8'h90);
    sync_master_model_inst.send(9'h066, 8);
    wt(10);
    chkb(`REG_PIR, `B_RECEIVE_COMPLETE_FLAG, 1'b0);
    // single receive bit set too: still receiving, never idle
    wr(`REG_TXSTAT, 8'h10);
    wr(`REG_RXSTAT, 8'hb0);
    chkb(`REG_BAUD, `B_RCIDL, 1'b0);
    sync_master_model_inst.send(9'h077, 8);
    wt(10);
    chk(`REG_RXDATA, 8'h77);
    // inverted polarity: bits are taken on the falling pin edge
    wr(`REG_RXSTAT, 8'h80);
    wr(`REG_BAUD, 8'h10);
    wr(`REG_RXSTAT, 8'h90);
    sync_master_model_inst.send(9'h04b, 8);
    wt(10);
    chk(`REG_RXDATA, 8'h4b);
    wr(`REG_BAUD, 8'h00);
    // transmit two bytes, second reload wakes the sleeper
    wr(`REG_RXSTAT, 8'h80);
    wr(`REG_TXSTAT, 8'h30);
    wr(`REG_PIE, 8'h10);
    wr(`REG_INTERRUPT_CONTROL, 8'h40);
    wr(`REG_TXDATA, 8'hc3);
    wt(3);
    chkb(`REG_PIR, `B_TRANSMIT_BUFFER_EMPTY_FLAG, 1'b1);
    wr(`REG_TXDATA, 8'h96);
    chkb(`REG_PIR, `B_TRANSMIT_BUFFER_EMPTY_FLAG, 1'b0);
    `CHK("oe", 1'b1, soe)
    sleep <= 1'b1;
    sync_master_model_inst.get(got, 8);
    `CHK("tx", 8'hc3, got)
    wt(10);
    `CHK("wake", 1'b1, wake)
    sleep <= 1'b0;
    sync_master_model_inst.get(got, 8);
    `CHK("tx", 8'h96, got)
    // nine-bit character takes its top bit from the stored ninth bit
    wt(5);
    wr(`REG_TXSTAT, 8'h71);
    wr(`REG_TXDATA, 8'h5a);
    wt(3);
    sync_master_model_inst.get(got, 9);
    `CHK("tx9", 9'h15a, got)
    wr(`REG_PIE, 8'h00);
    sleep <= 1'b1;
    wt(3);
    `CHK("wake", 1'b0, wake)
    sleep <= 1'b0;
    final_report();
  end
endmodule : tb
`default_nettype wire
